// ==== rtl/fhrs_pkg.sv ====
// Constants and types shared by the floppy host register set
package fhrs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets from the programmable I/O base
	localparam logic [2:0] OFF_DRIVE_CTL   = 3'h2;
	localparam logic [2:0] OFF_MAIN_STATUS = 3'h4;
	localparam logic [2:0] OFF_DATA_PORT   = 3'h5;
	localparam logic [2:0] OFF_SENSE_RATE  = 3'h7;
	localparam logic [15:0] IO_SPAN        = 16'h0008;

	////////////////////////////////////////////////////////////////////////
	// Drive control fields
	localparam int DC_MOTOR_B = 5;
	localparam int DC_MOTOR_A = 4;
	localparam int DC_GATE    = 3;
	localparam int DC_SOFT_N  = 2;
	localparam int DC_PICK    = 0;
	localparam logic [7:0] DC_WR_MASK = 8'h3D;
	localparam logic [7:0] DC_RESET   = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Main status fields
	localparam int MS_REQUEST = 7;
	localparam int MS_DIR     = 6;
	localparam int MS_PIO     = 5;
	localparam int MS_BUSY    = 4;
	localparam int MS_SEEK_B  = 1;
	localparam int MS_SEEK_A  = 0;

	////////////////////////////////////////////////////////////////////////
	// Read bus enables and input sense layout
	localparam int SENSE_MEDIA            = 7;
	localparam logic [7:0] OE_ALL         = 8'hFF;
	localparam logic [7:0] OE_NONE        = 8'h00;
	localparam logic [7:0] OE_SENSE       = 8'h80;
	localparam logic [7:0] BYTE_ZERO      = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Rate control codes {bit1,bit0} and divider steps
	localparam logic [1:0] RATE_500K = 2'b00;
	localparam logic [1:0] RATE_300K = 2'b01;
	localparam logic [1:0] RATE_250K = 2'b10;
	localparam logic [1:0] RATE_1M   = 2'b11;
	localparam logic [1:0] RATE_RESET = RATE_500K;
	localparam int SYS_CLK_KHZ  = 125000;
	localparam int DIV_KHZ_500K = 8000;
	localparam int DIV_KHZ_300K = 4800;
	localparam int DIV_KHZ_250K = 4000;
	localparam int DIV_KHZ_1M   = 16000;
	localparam int STEP_KHZ     = 100;
	localparam logic [10:0] RATE_MOD    = 11'(SYS_CLK_KHZ / STEP_KHZ);
	localparam logic [10:0] STEP_500K   = 11'(DIV_KHZ_500K / STEP_KHZ);
	localparam logic [10:0] STEP_300K   = 11'(DIV_KHZ_300K / STEP_KHZ);
	localparam logic [10:0] STEP_250K   = 11'(DIV_KHZ_250K / STEP_KHZ);
	localparam logic [10:0] STEP_1M     = 11'(DIV_KHZ_1M / STEP_KHZ);

	////////////////////////////////////////////////////////////////////////
	// Command byte buffer and result stack walk
	localparam int CMD_WIDTH = 8;
	localparam int CMD_DEPTH = 8;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_RES0 = 3'b001,
		PH_RES1 = 3'b011,
		PH_RES2 = 3'b010,
		PH_RES3 = 3'b110
	} fhrs_phase_t;

endpackage

// ==== rtl/fhrs_cmd_fifo.sv ====
// Command byte FIFO with registered head word
`timescale 1ns/100ps
module fhrs_cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wrPtr;
		logic [PW-1:0]               rdPtr;
		logic [CW-1:0]               count;
		logic                        notFull;
		logic                        valid;
		logic [WIDTH-1:0]            head;
	} fhrs_fifo_st_t;

	fhrs_fifo_st_t st;
	fhrs_fifo_st_t next_st;
	logic          push;
	logic          pop;

	////////////////////////////////////////////////////////////////////////
	// Pointer and count update; flags registered so both sides see flops
	always_comb
	begin
		next_st = st;
		push = inValid && st.notFull;
		pop = st.valid && outReady;
		if (push)
		begin
			next_st.mem[st.wrPtr] = inData;
			next_st.wrPtr = st.wrPtr + PW'(1);
		end
		if (pop)
			next_st.rdPtr = st.rdPtr + PW'(1);
		if (push && !pop)
			next_st.count = st.count + CW'(1);
		else if (pop && !push)
			next_st.count = st.count - CW'(1);
		if (flush)
		begin
			next_st.wrPtr = '0;
			next_st.rdPtr = '0;
			next_st.count = '0;
		end
		next_st.notFull = next_st.count < CW'(DEPTH);
		next_st.valid = next_st.count != '0;
		next_st.head = next_st.mem[next_st.rdPtr];
	end

	// Reset clears storage along with the bookkeeping; notFull loads high
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.notFull <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign inReady = st.notFull;
	assign outValid = st.valid;
	assign outData = st.head;
endmodule

// ==== rtl/fhrs_rate_div.sv ====
// Fractional divider giving the data rate clock as a tick stream
`timescale 1ns/100ps
module fhrs_rate_div (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [1:0] rateSel,
	output logic            rateTick
);
	typedef struct packed {
		logic [10:0] acc;
		logic        tick;
	} fhrs_div_st_t;

	fhrs_div_st_t st;
	fhrs_div_st_t next_st;
	logic [10:0]  step;
	logic [10:0]  sum;

	////////////////////////////////////////////////////////////////////////
	// Phase accumulator: 16/8/4.8/4 MHz cannot divide 125 MHz evenly
	always_comb
	begin
		next_st = st;
		case (rateSel)
			fhrs_pkg::RATE_500K: step = fhrs_pkg::STEP_500K; // see RL14
			fhrs_pkg::RATE_300K: step = fhrs_pkg::STEP_300K;
			fhrs_pkg::RATE_250K: step = fhrs_pkg::STEP_250K;
			fhrs_pkg::RATE_1M:   step = fhrs_pkg::STEP_1M;
			default:             step = fhrs_pkg::STEP_500K;
		endcase
		sum = st.acc + step;
		next_st.tick = sum >= fhrs_pkg::RATE_MOD;
		next_st.acc = next_st.tick ? sum - fhrs_pkg::RATE_MOD : sum;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign rateTick = st.tick;
endmodule

// ==== rtl/fhrs_register_set.sv ====
// Host register set of the floppy controller: decode, status and data port
//
// Summary of operation
// RL1: Drive control bit 5 runs motor B, bit 4 motor A, bit 3 gates irq/DMA.
// RL2: Bit 2 low holds controller in reset; rate and drive control keep values.
// RL3: Drive control bit 0 picks drive A when low, drive B when high.
// RL4: Interface reset clears drive control at offset 02h at any time.
// RL5: Main status bit 7 high only when a data port byte may move.
// RL6: Main status bit 6 reads 1 for host read, 0 for host write.
// RL7: Main status bit 5 shows programmed I/O mode from the timing command.
// RL8: Main status bit 4 busy from command start until result phase ends.
// RL9: Main status bits 1, 0 show drive B, A seeking; bits 3, 2 zero.
// RL10: Host reads main status at 04h before each programmed data byte.
// RL11: Data port at 05h fronts a stack; one entry per access.
// RL12: Input sense bit 7 reads the inverse of the media change pin.
// RL13: Input sense read leaves bits 6 to 0 undriven.
// RL14: Rate field picks 500K/300K/250K/1M; reduce-write set except 500K.
// RL15: Result 0 bits 7, 6 hold the completion code.
// RL16: Result 0: seek end bit 5, not ready 3, head 2, drive B/A 1, 0.
// RL17: Result 0 bit 4 flags track zero fault or outward step past zero.
// RL18: Result 1 bit 7 flags end of track; bits 6 and 3 read 0.
// RL19: Result 1 bit 5 flags CRC error, bit 4 overrun or underrun.
// RL20: Result 1 bit 2 no sector, bit 1 protected, bit 0 missing mark.
// RL21: Result 2 bits 6 to 0 carry mark, CRC, cylinder, scan flags; bit 7 zero.
// RL22: Result 3 mirrors fault, protect, ready, track zero, sides, head, unit.
`timescale 1ns/100ps
module fhrs_register_set (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ioReset,
	input  wire logic [15:0] ioBase,
	input  wire logic [15:0] hostAddr,
	input  wire logic        hostRd,
	input  wire logic        hostWr,
	input  wire logic [7:0]  hostWrData,
	output logic      [7:0]  hostRdData,
	output logic      [7:0]  hostRdOe,
	output logic             motorBOn,
	output logic             motorAOn,
	output logic             irqAndTransferGate,
	output logic             ctrlSoftResetN,
	output logic             drivePick,
	output logic             reduceWrite,
	output logic             rateTick,
	output logic             controllerBusy,
	output logic             cmdByteValid,
	input  wire logic        cmdByteReady,
	output logic      [7:0]  cmdByte,
	input  wire logic        programmedIoMode,
	input  wire logic        secondDriveSeeking,
	input  wire logic        firstDriveSeeking,
	input  wire logic        mediaChangedPinN,
	input  wire logic        resultLoad,
	input  wire logic [1:0]  completionCode,
	input  wire logic        positioningDoneFlag,
	input  wire logic        trackZeroFaultFlag,
	input  wire logic        driveNotReadyFlag,
	input  wire logic        headAddr,
	input  wire logic        trackEndFlag,
	input  wire logic        crcFaultFlag,
	input  wire logic        overrunFlag,
	input  wire logic        sectorMissingFlag,
	input  wire logic        writeProtectedFlag,
	input  wire logic        addressTagAbsentFlag,
	input  wire logic        deletedTagFlag,
	input  wire logic        payloadCrcFlag,
	input  wire logic        cylinderMismatchFlag,
	input  wire logic        compareEqualFlag,
	input  wire logic        compareUnmetFlag,
	input  wire logic        badTrackFlag,
	input  wire logic        payloadTagAbsentFlag,
	input  wire logic        driveFaultState,
	input  wire logic        writeProtectState,
	input  wire logic        driveReadyState,
	input  wire logic        trackZeroPinN,
	input  wire logic        doubleSidedState,
	input  wire logic        sideSelectState,
	input  wire logic        unitSelectHighState
);
	typedef struct packed {
		logic [7:0]           driveCtl;
		logic [1:0]           rate;
		logic                 reduceWr;
		logic                 busy;
		fhrs_pkg::fhrs_phase_t phase;
		logic [3:0][7:0]      result;
		logic [7:0]           rdData;
		logic [7:0]           rdOe;
	} fhrs_regs_t;

	fhrs_regs_t  st;
	fhrs_regs_t  next_st;
	logic [15:0] offset;
	logic        hit;
	logic        rdDrive;
	logic        rdMain;
	logic        rdPort;
	logic        rdSense;
	logic        wrDrive;
	logic        wrPort;
	logic        wrRate;
	logic        released;
	logic        inResult;
	logic        fifoInReady;
	logic        fifoPush;
	logic        lastPop;
	logic        hostRequest;
	logic [7:0]  mainStatus;
	logic [7:0]  stackTop;

	////////////////////////////////////////////////////////////////////////
	// Address decode; base alignment is left to the host
	assign offset = hostAddr - ioBase;
	assign hit = offset < fhrs_pkg::IO_SPAN;
	assign rdDrive = hostRd && hit && offset[2:0] == fhrs_pkg::OFF_DRIVE_CTL;
	assign rdMain = hostRd && hit && offset[2:0] == fhrs_pkg::OFF_MAIN_STATUS;
	assign rdPort = hostRd && hit && offset[2:0] == fhrs_pkg::OFF_DATA_PORT;
	assign rdSense = hostRd && hit && offset[2:0] == fhrs_pkg::OFF_SENSE_RATE;
	assign wrDrive = hostWr && hit && offset[2:0] == fhrs_pkg::OFF_DRIVE_CTL;
	assign wrPort = hostWr && hit && offset[2:0] == fhrs_pkg::OFF_DATA_PORT;
	assign wrRate = hostWr && hit && offset[2:0] == fhrs_pkg::OFF_SENSE_RATE;

	////////////////////////////////////////////////////////////////////////
	// Handshake terms seen by the host through main status
	assign released = st.driveCtl[fhrs_pkg::DC_SOFT_N];
	assign inResult = st.phase != fhrs_pkg::PH_IDLE;
	// Bytes only move while out of soft reset and room or data exists
	assign hostRequest = released && (inResult || fifoInReady); // see RL5
	// A byte refused for lack of room must not mark the controller busy
	assign fifoPush = wrPort && released && !inResult && fifoInReady;
	assign lastPop = rdPort && st.phase == fhrs_pkg::PH_RES3;

	// Reserved bits 3 and 2 are tied low
	always_comb
	begin
		mainStatus = fhrs_pkg::BYTE_ZERO;
		mainStatus[fhrs_pkg::MS_REQUEST] = hostRequest; // see RL5
		mainStatus[fhrs_pkg::MS_DIR] = inResult; // see RL6
		mainStatus[fhrs_pkg::MS_PIO] = programmedIoMode; // see RL7
		mainStatus[fhrs_pkg::MS_BUSY] = st.busy; // see RL8
		mainStatus[fhrs_pkg::MS_SEEK_B] = secondDriveSeeking; // see RL9
		mainStatus[fhrs_pkg::MS_SEEK_A] = firstDriveSeeking; // see RL9
	end

	// Stack entry under the data port, chosen by the walk state
	always_comb
	begin
		case (st.phase)
			fhrs_pkg::PH_RES0: stackTop = st.result[0];
			fhrs_pkg::PH_RES1: stackTop = st.result[1];
			fhrs_pkg::PH_RES2: stackTop = st.result[2];
			fhrs_pkg::PH_RES3: stackTop = st.result[3];
			default:           stackTop = fhrs_pkg::BYTE_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register update
	always_comb
	begin
		next_st = st;
		// Drive control; interface reset overrides any write
		if (wrDrive)
			next_st.driveCtl = hostWrData & fhrs_pkg::DC_WR_MASK; // see RL1
		if (ioReset)
			next_st.driveCtl = fhrs_pkg::DC_RESET; // see RL4
		// Rate write shares offset with input sense and is kept by soft reset
		if (wrRate)
			next_st.rate = hostWrData[1:0]; // see RL2
		next_st.reduceWr = next_st.rate != fhrs_pkg::RATE_500K; // see RL14

		// Result stack: each data port read in the result phase steps exactly one entry
		if (rdPort)
		begin
			case (st.phase)
				fhrs_pkg::PH_RES0: next_st.phase = fhrs_pkg::PH_RES1; // see RL11
				fhrs_pkg::PH_RES1: next_st.phase = fhrs_pkg::PH_RES2;
				fhrs_pkg::PH_RES2: next_st.phase = fhrs_pkg::PH_RES3;
				fhrs_pkg::PH_RES3: next_st.phase = fhrs_pkg::PH_IDLE;
				default:           next_st.phase = fhrs_pkg::PH_IDLE;
			endcase
		end
		// Busy drops after the last result byte or in soft reset; a new command wins
		if (lastPop)
			next_st.busy = 1'b0;
		if (fifoPush)
			next_st.busy = 1'b1; // see RL8
		// A fresh result set outranks the final pop of the old one
		if (resultLoad)
		begin
			next_st.phase = fhrs_pkg::PH_RES0;
			next_st.result[0] = {completionCode, positioningDoneFlag, // see RL15
				trackZeroFaultFlag, driveNotReadyFlag, headAddr, // see RL17
				st.driveCtl[fhrs_pkg::DC_PICK], !st.driveCtl[fhrs_pkg::DC_PICK]}; // see RL16
			next_st.result[1] = {trackEndFlag, 1'b0, crcFaultFlag, // see RL18
				overrunFlag, 1'b0, sectorMissingFlag, // see RL19
				writeProtectedFlag, addressTagAbsentFlag}; // see RL20
			next_st.result[2] = {1'b0, deletedTagFlag, payloadCrcFlag, // see RL21
				cylinderMismatchFlag, compareEqualFlag, compareUnmetFlag,
				badTrackFlag, payloadTagAbsentFlag};
			next_st.result[3] = {driveFaultState, writeProtectState, // see RL22
				driveReadyState, !trackZeroPinN, doubleSidedState,
				sideSelectState, unitSelectHighState, st.driveCtl[fhrs_pkg::DC_PICK]};
		end
		// Soft reset idles the controller function only
		if (!released)
		begin
			next_st.phase = fhrs_pkg::PH_IDLE; // see RL2
			next_st.busy = 1'b0;
		end

		// Read answer one cycle after the strobe; bus released otherwise
		next_st.rdOe = fhrs_pkg::OE_NONE;
		if (rdDrive)
		begin
			next_st.rdData = st.driveCtl;
			next_st.rdOe = fhrs_pkg::OE_ALL;
		end
		else if (rdMain)
		begin
			next_st.rdData = mainStatus;
			next_st.rdOe = fhrs_pkg::OE_ALL;
		end
		else if (rdPort)
		begin
			next_st.rdData = stackTop; // see RL11
			next_st.rdOe = fhrs_pkg::OE_ALL;
		end
		else if (rdSense)
		begin
			next_st.rdData = fhrs_pkg::BYTE_ZERO;
			next_st.rdData[fhrs_pkg::SENSE_MEDIA] = !mediaChangedPinN; // see RL12
			next_st.rdOe = fhrs_pkg::OE_SENSE; // see RL13
		end
	end

	// Drive control resets low, so the controller starts held in soft reset
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.driveCtl <= fhrs_pkg::DC_RESET;
			st.rate <= fhrs_pkg::RATE_RESET;
			st.phase <= fhrs_pkg::PH_IDLE;
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// Command byte buffer; full shows as a low request bit to the host outside the result phase
	fhrs_cmd_fifo #(
		.WIDTH (fhrs_pkg::CMD_WIDTH),
		.DEPTH (fhrs_pkg::CMD_DEPTH)
	) u_cmd_fifo (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.flush    (!released),
		.inValid  (fifoPush),
		.inReady  (fifoInReady),
		.inData   (hostWrData),
		.outValid (cmdByteValid),
		.outReady (cmdByteReady),
		.outData  (cmdByte)
	);

	// Data rate clock follows the rate field
	fhrs_rate_div u_rate_div (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.rateSel  (st.rate),
		.rateTick (rateTick)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from register bits
	assign motorBOn = st.driveCtl[fhrs_pkg::DC_MOTOR_B]; // see RL1
	assign motorAOn = st.driveCtl[fhrs_pkg::DC_MOTOR_A];
	assign irqAndTransferGate = st.driveCtl[fhrs_pkg::DC_GATE];
	assign ctrlSoftResetN = st.driveCtl[fhrs_pkg::DC_SOFT_N];
	assign drivePick = st.driveCtl[fhrs_pkg::DC_PICK]; // see RL3
	assign reduceWrite = st.reduceWr;
	assign controllerBusy = st.busy;
	assign hostRdData = st.rdData;
	assign hostRdOe = st.rdOe;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_MOTOR_GATE: assert property (wrDrive && !ioReset |=> // see RL1
		motorBOn == $past(hostWrData[5]) && motorAOn == $past(hostWrData[4])
		&& irqAndTransferGate == $past(hostWrData[3]))
		else $error("drive control motor or gate bit not taken");
	AST_SOFT_KEEPS: assert property (!ctrlSoftResetN && !wrRate && !wrDrive && !ioReset // see RL2
		|=> $stable(st.rate) && $stable(st.driveCtl) && !controllerBusy)
		else $error("soft reset disturbed registers or left busy");
	AST_PICK: assert property (wrDrive && !ioReset |=> drivePick == $past(hostWrData[0])) // see RL3
		else $error("drive pick not taken");
	AST_IO_RESET: assert property (ioReset |=> !motorAOn && !motorBOn && !ctrlSoftResetN // see RL4
		&& !drivePick && !irqAndTransferGate)
		else $error("interface reset did not clear drive control");
	AST_READ_DIR: assert property (rdMain && inResult && released |=> // see RL6
		hostRdData[7:6] == 2'b11 && hostRdOe == 8'hFF)
		else $error("result phase not shown as host read request");
	AST_MAIN_BITS: assert property (rdMain |=> hostRdData[3:2] == 2'b00 // see RL9
		&& hostRdData[1:0] == $past({secondDriveSeeking, firstDriveSeeking})
		&& hostRdData[5] == $past(programmedIoMode))
		else $error("main status seek or mode bits wrong");
	AST_NO_REQ_HELD: assert property (!ctrlSoftResetN |-> !hostRequest) // see RL5
		else $error("transfer request raised during soft reset");
	AST_BUSY_HOLD: assert property (controllerBusy && !lastPop && ctrlSoftResetN // see RL8
		|=> controllerBusy)
		else $error("busy cleared before result phase ended");
	AST_ONE_STEP: assert property (rdPort && inResult && released && !resultLoad // see RL11
		|=> st.phase != $past(st.phase) ##1 1'b1)
		else $error("data port read did not step one entry");
	AST_SENSE: assert property (rdSense |=> hostRdOe == 8'h80 // see RL13
		&& hostRdData[7] == !$past(mediaChangedPinN))
		else $error("input sense read wrong");
	AST_ST1_ZERO: assert property (rdPort && st.phase == fhrs_pkg::PH_RES1 // see RL18
		|=> hostRdData[6] == 1'b0 && hostRdData[3] == 1'b0)
		else $error("result 1 fixed zero bits set");
	AST_REDUCE: assert property (wrRate |=> ##1 reduceWrite == ($past(hostWrData[1:0], 2) != 2'b00)) // see RL14
		else $error("reduce write does not follow rate");

	// Busy and result entry follow accepted events only
	AST_BUSY_SET: assert property (fifoPush |=> controllerBusy) // see RL8
		else $error("accepted command byte did not raise busy");
	AST_RESULT_REQ: assert property (resultLoad && released && !ioReset && !wrDrive // see RL5
		|=> hostRequest && mainStatus[fhrs_pkg::MS_DIR])
		else $error("loaded result not offered to the host");

	// Main scenarios reached by the bench
	COV_CMD_BYTE: cover property (fifoPush ##1 cmdByteValid);
	COV_FULL_STACK: cover property (st.phase == fhrs_pkg::PH_RES3 && rdPort ##1 st.phase == fhrs_pkg::PH_IDLE);
	COV_FIFO_FULL: cover property (released && !fifoInReady);
	COV_SENSE: cover property (rdSense ##1 hostRdData[7]);
	COV_RESULT_WALK: cover property (resultLoad && released ##1 inResult);
endmodule

// ==== dv/fhrs_core_model.sv ====
// Controller core stand-in that drains command bytes
`timescale 1ns/100ps
module fhrs_core_model (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       stall,
	input  wire logic       cmdByteValid,
	input  wire logic [7:0] cmdByte,
	output logic            cmdByteReady
);
	logic [7:0] got [0:15];
	int         count;
	////////////////////////////////////////
	// Stall lets the bench keep the queue full
	assign cmdByteReady = !stall;
	// Record popped bytes in arrival order
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			count <= 0;
		else if (cmdByteValid && cmdByteReady)
		begin
			got[count[3:0]] <= cmdByte;
			count <= count + 1;
		end
	end
endmodule

// ==== dv/fhrs_register_set_tb.sv ====
// Self-checking bench for the floppy host register set
`timescale 1ns/100ps
module fhrs_register_set_tb;
	logic        clk_sys, rst_n, ioReset, hostRd, hostWr, cmdByteReady, stall;
	logic [15:0] ioBase, hostAddr;
	logic [7:0]  hostWrData, hostRdData, hostRdOe, cmdByte, v, oe;
	logic        motorBOn, motorAOn, irqAndTransferGate, ctrlSoftResetN, drivePick;
	logic        reduceWrite, rateTick, controllerBusy, cmdByteValid, resultLoad;
	logic        programmedIoMode, secondDriveSeeking, firstDriveSeeking, mediaChangedPinN;
	logic [1:0]  completionCode;
	logic        positioningDoneFlag, trackZeroFaultFlag, driveNotReadyFlag, headAddr;
	logic        trackEndFlag, crcFaultFlag, overrunFlag, sectorMissingFlag, writeProtectedFlag;
	logic        addressTagAbsentFlag, deletedTagFlag, payloadCrcFlag, cylinderMismatchFlag;
	logic        compareEqualFlag, compareUnmetFlag, badTrackFlag, payloadTagAbsentFlag;
	logic        driveFaultState, writeProtectState, driveReadyState, trackZeroPinN;
	logic        doubleSidedState, sideSelectState, unitSelectHighState;
	int          fails, num_checks, n;
	// Rows: written byte, read back; reserved bits drop
	localparam logic [15:0] DC_ROWS [4] = '{16'hFF3D, 16'h2121, 16'h1414, 16'h0C0C};
	// Rows: code, reduce write, ticks per 1250 cycles
	localparam logic [11:0] RT_ROWS [4] = '{12'h050, 12'h530, 12'h928, 12'hDA0};
	localparam logic [7:0]  RES [4]     = '{8'h6A, 8'h92, 8'h55, 8'hB5};

	fhrs_register_set u_dut (.*);
	fhrs_core_model u_core (.*);

	////////////////////////////////////////
	// Clock, 8 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Bus cycles: strobe for one edge, answer one edge later
	task automatic wr(input logic [2:0] off, input logic [7:0] d);
		@(posedge clk_sys);
		hostWr <= 1'b1;
		hostAddr <= ioBase + {13'h0000, off};
		hostWrData <= d;
		@(posedge clk_sys);
		hostWr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [2:0] off);
		@(posedge clk_sys);
		hostRd <= 1'b1;
		hostAddr <= ioBase + {13'h0000, off};
		@(posedge clk_sys);
		hostRd <= 1'b0;
		#1;
		v = hostRdData;
		oe = hostRdOe;
	endtask

	// Status is read before every data byte
	task automatic put(input logic [7:0] d);
		rd(3'h4);
		wr(3'h5, d);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	// Main sequence
	initial
	begin
		{rst_n, ioReset, hostRd, hostWr, stall, resultLoad} = 6'h00;
		{programmedIoMode, secondDriveSeeking, firstDriveSeeking, mediaChangedPinN} = 4'hD;
		{completionCode, positioningDoneFlag, trackZeroFaultFlag, driveNotReadyFlag, headAddr,
			trackEndFlag, crcFaultFlag, overrunFlag, sectorMissingFlag, writeProtectedFlag,
			addressTagAbsentFlag, deletedTagFlag, payloadCrcFlag, cylinderMismatchFlag,
			compareEqualFlag, compareUnmetFlag, badTrackFlag, payloadTagAbsentFlag,
			driveFaultState, writeProtectState, driveReadyState, trackZeroPinN,
			doubleSidedState, sideSelectState, unitSelectHighState} = 26'h0000000;
		ioBase = 16'h03F0;
		hostAddr = 16'h0000;
		hostWrData = 8'h00;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		chk("pins", {motorBOn, motorAOn, irqAndTransferGate, ctrlSoftResetN, drivePick}, 8'h00);
		chk("oe", hostRdOe, 8'h00);
		// Drive control rows, soft reset bit included
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h2, DC_ROWS[i][15:8]);
			chk("pins", {motorBOn, motorAOn, irqAndTransferGate, ctrlSoftResetN, drivePick},
				{3'h0, DC_ROWS[i][5:2], DC_ROWS[i][0]});
			rd(3'h2);
			chk("drive", v, DC_ROWS[i][7:0]);
		end
		// Rate codes: count ticks over one divider period
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h7, {6'h00, RT_ROWS[i][11:10]});
			chk("rw", {7'h00, reduceWrite}, {7'h00, RT_ROWS[i][8]});
			n = 0;
			repeat (1250)
			begin
				@(posedge clk_sys);
				#1;
				n += int'(rateTick);
			end
			chk("ticks", 8'((n - int'(RT_ROWS[i][7:0]) + 1) / 3), 8'h00);
		end
		// Input sense and an unmapped offset
		@(posedge clk_sys);
		mediaChangedPinN <= 1'b0;
		rd(3'h7);
		chk("sense", v & 8'h80, 8'h80);
		chk("sense oe", oe, 8'h80);
		rd(3'h1);
		chk("hole oe", oe, 8'h00);
		// Interface reset beats a same-cycle write
		@(posedge clk_sys);
		ioReset <= 1'b1;
		hostWr <= 1'b1;
		hostAddr <= ioBase + 16'h0002;
		hostWrData <= 8'h3D;
		@(posedge clk_sys);
		ioReset <= 1'b0;
		hostWr <= 1'b0;
		rd(3'h2);
		chk("drive", v, 8'h00);
		chk("rw", {7'h00, reduceWrite}, 8'h01);
		rd(3'h4);
		chk("status", v, 8'h22);
		wr(3'h5, 8'h77);
		chk("valid", {7'h00, cmdByteValid}, 8'h00);
		// Out of soft reset, one command byte
		wr(3'h2, 8'h0D);
		put(8'hA5);
		chk("status", v, 8'hA2);
		chk("head", cmdByte, 8'hA5);
		chk("busy", {7'h00, controllerBusy}, 8'h01);
		// Fill with the core stalled, then drain
		@(posedge clk_sys);
		stall <= 1'b1;
		for (int i = 0; i < 8; i++)
			put(8'h10 + 8'(i));
		rd(3'h4);
		chk("status", v, 8'h32);
		wr(3'h5, 8'h99);
		@(posedge clk_sys);
		stall <= 1'b0;
		n = 0;
		while (u_core.count != 9 && n < 100)
		begin
			@(posedge clk_sys);
			n++;
		end
		// A stuck drain counts once; the checks below then fail too
		if (n == 100)
			fails++;
		repeat (4) @(posedge clk_sys);
		chk("drained", 8'(u_core.count), 8'h09);
		for (int i = 0; i < 8; i++)
			chk("order", u_core.got[i + 1], 8'h10 + 8'(i));
		// Result phase walk
		@(posedge clk_sys);
		{completionCode, positioningDoneFlag, trackZeroFaultFlag, driveNotReadyFlag, headAddr,
			trackEndFlag, crcFaultFlag, overrunFlag, sectorMissingFlag, writeProtectedFlag,
			addressTagAbsentFlag, deletedTagFlag, payloadCrcFlag, cylinderMismatchFlag,
			compareEqualFlag, compareUnmetFlag, badTrackFlag, payloadTagAbsentFlag,
			driveFaultState, writeProtectState, driveReadyState, trackZeroPinN,
			doubleSidedState, sideSelectState, unitSelectHighState} <= 26'h1AAAAD2;
		resultLoad <= 1'b1;
		@(posedge clk_sys);
		resultLoad <= 1'b0;
		rd(3'h4);
		chk("status", v, 8'hF2);
		for (int i = 0; i < 4; i++)
		begin
			rd(3'h5);
			chk("result", v, RES[i]);
			if (i < 3)
				chk("busy", {7'h00, controllerBusy}, 8'h01);
		end
		@(posedge clk_sys);
		#1;
		chk("busy", {7'h00, controllerBusy}, 8'h00);
		rd(3'h5);
		chk("idle", v, 8'h00);
		// Mid-run reset returns rate, drive control and queue to defaults
		@(posedge clk_sys);
		rst_n <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		chk("reset", {reduceWrite, motorAOn, irqAndTransferGate, ctrlSoftResetN, drivePick,
			controllerBusy, cmdByteValid, rateTick}, 8'h00);
		give_verdict();
	end
endmodule
